// File: logic/mtrc_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module mtrc_ctl (
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire logic                    clk_en,
    // type resolution
    input  wire logic                    global_nofill_flag,
    input  wire logic                    global_write_policy_flag,
    input  wire logic [2:0]              range_type,
    input  wire logic                    range_regs_off,
    input  wire logic [63:0]             page_attr_table,
    input  wire logic                    page_attr_sel,
    input  wire logic                    page_cache_off_bit,
    input  wire logic                    page_write_through_bit,
    output logic [2:0]                   eff_type,
    output logic                         eff_snoop,
    output logic                         eff_strict_order,
    output logic                         eff_impl_defined,
    output logic                         cache_fill_en,
    output logic                         read_hit_en,
    output logic                         l3_enable,
    // misc enable register access
    input  wire logic                    misc_wr,
    input  wire logic [63:0]             misc_wdata,
    output logic [63:0]                  misc_rdata,
    // maintenance requests
    input  wire logic                    req_valid,
    input  wire logic [1:0]              req_op,
    input  wire logic [31:0]             req_addr,
    output logic                         req_ready,
    output logic                         req_done,
    // internal cache engine handshake
    output logic                         wb_all_start,
    input  wire logic                    wb_all_done,
    output logic                         inv_all,
    output logic                         line_flush,
    output logic [31:0]                  line_flush_addr,
    // special bus cycle
    output logic                         bus_special,
    output logic [7:0]                   bus_special_code,
    // stores and code coherence
    input  wire logic                    store_valid,
    input  wire logic                    store_nontemporal,
    input  wire logic                    store_hits_code_line,
    input  wire logic                    store_hits_prefetch,
    input  wire logic                    store_hits_trace,
    input  wire logic                    snoop_hits_trace,
    input  wire logic                    serialize,
    output logic                         store_alloc,
    output logic                         code_line_inv,
    output logic                         prefetch_inv,
    output logic                         trace_inv,
    output logic                         icache_resync
);
    typedef enum logic [2:0] {
        MTRC_IDLE  = 3'b000,
        MTRC_WBALL = 3'b001,
        MTRC_INV   = 3'b010,
        MTRC_BUSWB = 3'b011,
        MTRC_BUSIN = 3'b100,
        MTRC_DONE  = 3'b101
    } mtrc_state_t;

    mtrc_state_t  state_r;
    mtrc_state_t  state_nxt;
    logic [63:0]  misc_r;
    logic         wb_mode_r;

    // entry select and combine with range type
    // entry select
    wire  [2:0]   pat_idx = {page_attr_sel, page_cache_off_bit,
                             page_write_through_bit};
    wire  [2:0]   pat_ent = page_attr_table[{pat_idx, 3'h0} +: 3];
    wire          flags_clr = !global_nofill_flag &&
                              !global_write_policy_flag;

    // returns {impl_defined, type}; in the table
    function automatic logic [3:0] mtrc_combine(input logic [2:0] rt,
                                                input logic [2:0] pe);
        logic [2:0] t;
        logic       u;
        t = 3'(mtrc_pkg::MTRC_UC);
        u = 1'b0;
        case (rt)
            3'(mtrc_pkg::MTRC_UC):
                t = (pe == 3'(mtrc_pkg::MTRC_WC)) ? 3'(mtrc_pkg::MTRC_WC)
                                                  : 3'(mtrc_pkg::MTRC_UC);
            3'(mtrc_pkg::MTRC_WC):
                if (pe == 3'(mtrc_pkg::MTRC_UC))
                    t = 3'(mtrc_pkg::MTRC_UC);
                else if (pe == 3'(mtrc_pkg::MTRC_WT) ||
                         pe == 3'(mtrc_pkg::MTRC_WP))
                    u = 1'b1;
                else
                    t = 3'(mtrc_pkg::MTRC_WC);
            3'(mtrc_pkg::MTRC_WT):
                if (pe == 3'(mtrc_pkg::MTRC_WC))
                    t = 3'(mtrc_pkg::MTRC_WC);
                else if (pe == 3'(mtrc_pkg::MTRC_WT) ||
                         pe == 3'(mtrc_pkg::MTRC_WB))
                    t = 3'(mtrc_pkg::MTRC_WT);
                else if (pe == 3'(mtrc_pkg::MTRC_WP))
                    u = 1'b1;
            3'(mtrc_pkg::MTRC_WB):
                t = (pe == 3'(mtrc_pkg::MTRC_UCW)) ? 3'(mtrc_pkg::MTRC_UC)
                                                   : pe;
            3'(mtrc_pkg::MTRC_WP):
                if (pe == 3'(mtrc_pkg::MTRC_WC))
                    t = 3'(mtrc_pkg::MTRC_WC);
                else if (pe == 3'(mtrc_pkg::MTRC_WB) ||
                         pe == 3'(mtrc_pkg::MTRC_WP))
                    t = 3'(mtrc_pkg::MTRC_WP);
                else if (pe != 3'(mtrc_pkg::MTRC_UC))
                    u = 1'b1;
            default: u = 1'b1;
        endcase
        if (u)
            t = 3'(mtrc_pkg::MTRC_UC);
        return {u, t};
    endfunction

    wire  [3:0]   comb = mtrc_combine(range_type, pat_ent);
    wire  [2:0]   comb_type = comb[2:0];
    wire          uc_from_range = range_type == 3'(mtrc_pkg::MTRC_UC);

    // combine only when flags clear; otherwise range type
    // no-fill alone leaves type as range says, uncached only by ranges
    wire  [2:0]   eff_type_nxt = range_regs_off ? 3'(mtrc_pkg::MTRC_UC) :
                                 flags_clr ? comb_type : range_type;
    // snoop unless uncached came from the ranges
    wire          snoop_nxt = !(range_regs_off || uc_from_range);

    // resolved attributes registered
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            eff_type         <= 3'(mtrc_pkg::MTRC_UC);
            eff_snoop        <= 1'b0;
            eff_strict_order <= 1'b1;
            eff_impl_defined <= 1'b0;
        end
        else if (clk_en)
        begin
            eff_type         <= eff_type_nxt;
            eff_snoop        <= snoop_nxt;
            // strict order only from uncached ranges
            eff_strict_order <= range_regs_off || uc_from_range;
            eff_impl_defined <= flags_clr && comb[3];
        end
    end

    // no-fill keeps read hits, stops fills
    assign cache_fill_en = !global_nofill_flag;
    assign read_hit_en   = 1'b1;

    // misc enable register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            misc_r <= mtrc_pkg::MTRC_MISC_RST;
        else if (clk_en && misc_wr)
            misc_r <= misc_wdata;
    end
    assign misc_rdata = misc_r;
    assign l3_enable  = !misc_r[mtrc_pkg::MTRC_L3_DIS_BIT];

    // maintenance sequencer
    wire          take  = clk_en && req_valid && state_r == MTRC_IDLE;
    assign req_ready = state_r == MTRC_IDLE;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            MTRC_IDLE:
                if (req_valid)
                begin
                    if (req_op == 2'h1)
                        state_nxt = MTRC_WBALL;
                    else if (req_op == 2'h0)
                        state_nxt = MTRC_INV;
                    else
                        state_nxt = MTRC_DONE;
                end
            MTRC_WBALL:
                if (wb_all_done)
                    state_nxt = MTRC_INV;
            MTRC_INV:
                state_nxt = wb_mode_r ? MTRC_BUSWB : MTRC_BUSIN;
            MTRC_BUSWB:
                state_nxt = MTRC_BUSIN;
            MTRC_BUSIN:
                state_nxt = MTRC_DONE;
            MTRC_DONE:
                state_nxt = MTRC_IDLE;
            default:
                state_nxt = MTRC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r   <= MTRC_IDLE;
            wb_mode_r <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            if (take)
                wb_mode_r <= req_op == 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            line_flush      <= 1'b0;
            line_flush_addr <= 32'h0;
        end
        else if (clk_en)
        begin
            line_flush <= take && req_op == 2'h2;
            if (take && req_op == 2'h2)
                line_flush_addr <= {req_addr[31:mtrc_pkg::MTRC_LINE_LSB],
                                    6'h0};
        end
    end

    // engine and bus strobes decoded from state
    assign wb_all_start = state_r == MTRC_WBALL;
    assign inv_all      = state_r == MTRC_INV;
    assign bus_special  = state_r == MTRC_BUSWB || state_r == MTRC_BUSIN;
    assign bus_special_code = (state_r == MTRC_BUSWB) ?
                              mtrc_pkg::MTRC_CMD_WBACK :
                              (state_r == MTRC_BUSIN) ?
                              mtrc_pkg::MTRC_CMD_INV : 8'h0;
    assign req_done     = state_r == MTRC_DONE;

    // store side coherence pulses
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            store_alloc   <= 1'b0;
            code_line_inv <= 1'b0;
            prefetch_inv  <= 1'b0;
            trace_inv     <= 1'b0;
            icache_resync <= 1'b0;
        end
        else if (clk_en)
        begin
            store_alloc   <= store_valid && !store_nontemporal &&
                             cache_fill_en;
            code_line_inv <= store_valid && store_hits_code_line;
            prefetch_inv  <= (store_valid && store_hits_prefetch) ||
                             serialize;
            trace_inv     <= (store_valid && store_hits_trace) ||
                             snoop_hits_trace;
            icache_resync <= serialize;
        end
    end

    // straddling store may issue twice; no merging here

    chk_wbinv_order: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && state_r == MTRC_INV && wb_mode_r |=>
        !clk_en || bus_special_code == mtrc_pkg::MTRC_CMD_WBACK)
        else $error("write-back cycle missing after invalidate");
    chk_inv_nowb: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        take && req_op == 2'h0 |=> !clk_en || inv_all)
        else $error("invalidate-all did not invalidate next");
    chk_nt_alloc: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && store_valid && store_nontemporal |=> !store_alloc)
        else $error("non-temporal store allocated");
    chk_l3_bit: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        l3_enable == !misc_rdata[mtrc_pkg::MTRC_L3_DIS_BIT])
        else $error("third-level enable mismatch");
    chk_trace_snoop: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && snoop_hits_trace |=> trace_inv)
        else $error("trace cache not invalidated");
    chk_uc_range: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && uc_from_range && !range_regs_off && flags_clr &&
        pat_ent != 3'(mtrc_pkg::MTRC_WC) |=>
        eff_type == 3'(mtrc_pkg::MTRC_UC) && !eff_snoop)
        else $error("uncached range resolution wrong");
    chk_undef_uc: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        eff_impl_defined |-> eff_type == 3'(mtrc_pkg::MTRC_UC))
        else $error("undefined pair not uncached");
    chk_resync: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && serialize |=> icache_resync && prefetch_inv)
        else $error("serialize did not resync");
    chk_flush_line: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        take && req_op == 2'h2 |=>
        line_flush && line_flush_addr[5:0] == 6'h0)
        else $error("line flush missing or unaligned");
    chk_code_inv: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && store_valid && store_hits_code_line |=> code_line_inv)
        else $error("code line not invalidated");
    chk_prefetch_inv: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && store_valid && store_hits_prefetch |=> prefetch_inv)
        else $error("prefetch queue not invalidated");
    chk_flag_type: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && !flags_clr && !range_regs_off |=>
        eff_type == $past(range_type))
        else $error("flags set but type not from ranges");
    cov_wbinv: cover property (@(posedge sys_clk) state_r == MTRC_BUSWB);
    cov_flush: cover property (@(posedge sys_clk) line_flush);
    cov_undef: cover property (@(posedge sys_clk) eff_impl_defined);
    cov_cache_off: cover property (@(posedge sys_clk)
        global_nofill_flag && range_regs_off && state_r == MTRC_BUSWB);
endmodule
`default_nettype wire

// File: pkg/mtrc_pkg.sv
package mtrc_pkg;
    typedef enum logic [2:0] {
        MTRC_UC  = 3'h0,
        MTRC_WC  = 3'h1,
        MTRC_WT  = 3'h4,
        MTRC_WP  = 3'h5,
        MTRC_WB  = 3'h6,
        MTRC_UCW = 3'h7
    } mtrc_type_t;
    localparam int MTRC_L3_DIS_BIT = 6;
    localparam int MTRC_ADDR_W     = 32;
    localparam int MTRC_LINE_LSB   = 6;
    localparam logic [7:0] MTRC_CMD_INV   = 8'h01;
    localparam logic [7:0] MTRC_CMD_WBACK = 8'h02;
    localparam logic [7:0] MTRC_CMD_FLUSH = 8'h03;
    localparam logic [63:0] MTRC_MISC_RST = 64'h0;
endpackage

// File: sim/mtrc_ctl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mtrc_ctl_tb_top;
    logic        sys_clk, nrst, clk_en, global_nofill_flag, misc_wr;
    logic        global_write_policy_flag, range_regs_off, page_attr_sel;
    logic        page_cache_off_bit, page_write_through_bit, req_valid;
    logic        req_ready, req_done, wb_all_start, wb_all_done, inv_all;
    logic        line_flush, bus_special, store_valid, store_nontemporal;
    logic        store_hits_code_line, store_hits_prefetch, store_hits_trace;
    logic        snoop_hits_trace, serialize, store_alloc, code_line_inv;
    logic        prefetch_inv, trace_inv, icache_resync, eff_snoop;
    logic        eff_strict_order, eff_impl_defined, cache_fill_en;
    logic        read_hit_en, l3_enable;
    logic [1:0]  req_op;
    logic [2:0]  range_type, eff_type;
    logic [3:0]  lat;
    logic [7:0]  bus_special_code;
    logic [31:0] req_addr, line_flush_addr, fl_addr;
    logic [63:0] page_attr_table, misc_wdata, misc_rdata;
    int          error_cnt, num_checks, t_inv, t_b1, t_b2, t_fl, t_done;
    int          t_wbl, n_wb, n_bus, n_fl;
    // entry codes: UC, weak UC, WC, WT, WB, WP
    logic [2:0]  codes [6] = '{mtrc_pkg::MTRC_UC, mtrc_pkg::MTRC_UCW,
        mtrc_pkg::MTRC_WC, mtrc_pkg::MTRC_WT, mtrc_pkg::MTRC_WB,
        mtrc_pkg::MTRC_WP};
    // result index per range row UC WC WT WB WP, 6 marks undefined pair
    int          res [5][6] = '{'{0, 0, 2, 0, 0, 0}, '{0, 2, 2, 6, 2, 6},
        '{0, 0, 2, 3, 3, 6}, '{0, 0, 2, 3, 4, 5}, '{0, 6, 2, 6, 5, 5}};

    mtrc_ctl DUT (
        .sys_clk, .nrst, .clk_en, .global_nofill_flag,
        .global_write_policy_flag, .range_type, .range_regs_off,
        .page_attr_table, .page_attr_sel, .page_cache_off_bit,
        .page_write_through_bit, .eff_type, .eff_snoop, .eff_strict_order,
        .eff_impl_defined, .cache_fill_en, .read_hit_en, .l3_enable,
        .misc_wr, .misc_wdata, .misc_rdata, .req_valid, .req_op, .req_addr,
        .req_ready, .req_done, .wb_all_start, .wb_all_done, .inv_all,
        .line_flush, .line_flush_addr, .bus_special, .bus_special_code,
        .store_valid, .store_nontemporal, .store_hits_code_line,
        .store_hits_prefetch, .store_hits_trace, .snoop_hits_trace,
        .serialize, .store_alloc, .code_line_inv, .prefetch_inv,
        .trace_inv, .icache_resync
    );
    mtrc_eng_model ENG (.sys_clk, .nrst, .lat, .wb_all_start, .wb_all_done);

    // free-running core clock
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [63:0] got, exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got,
                     exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic test_types();
        int e;
        for (int r = 0; r < 5; r++)
            for (int k = 0; k < 6; k++)
            begin
                range_type = codes[r == 0 ? 0 : r + 1];
                page_attr_table = {8{5'h00, codes[k]}};
                @(negedge sys_clk);
                e = res[r][k];
                chk(eff_type, codes[e % 6], "type");
                chk(eff_impl_defined, e == 6, "undefined");
                if (e % 6 == 0)
                    chk(eff_snoop, r != 0, "snoop");
            end
        $display("test types done");
    endtask

    // entry picked by select, cache-off and write-through bits
    task automatic test_index();
        range_type = codes[4];
        for (int i = 0; i < 8; i++)
            page_attr_table[8*i +: 8] = {5'h00, codes[(i + 2) % 6]};
        for (int i = 0; i < 8; i++)
        begin
            {page_attr_sel, page_cache_off_bit, page_write_through_bit} =
                3'(i);
            @(negedge sys_clk);
            chk(eff_type, codes[res[3][(i + 2) % 6]], "index");
        end
        {page_attr_sel, page_cache_off_bit, page_write_through_bit} = 3'h0;
        $display("test index done");
    endtask

    task automatic test_flags();
        range_type = codes[4];
        page_attr_table = {8{5'h00, codes[0]}};
        global_nofill_flag = 1'b1;
        @(negedge sys_clk);
        chk(eff_type, codes[4], "nofill type");
        chk(eff_strict_order, 1'b0, "nofill order");
        chk(cache_fill_en, 1'b0, "fill");
        chk(read_hit_en, 1'b1, "read hit");
        range_regs_off = 1'b1;
        @(negedge sys_clk);
        chk(eff_type, codes[0], "off type");
        chk(eff_strict_order, 1'b1, "off order");
        chk(eff_snoop, 1'b0, "off snoop");
        {global_nofill_flag, range_regs_off} = 2'h0;
        global_write_policy_flag = 1'b1;
        range_type = codes[3];
        page_attr_table = {8{5'h00, codes[2]}};
        @(negedge sys_clk);
        chk(eff_type, codes[3], "policy type");
        global_write_policy_flag = 1'b0;
        @(negedge sys_clk);
        chk(eff_type, codes[2], "clear type");
        // enable low freezes the resolved type
        clk_en = 1'b0;
        range_regs_off = 1'b1;
        @(negedge sys_clk);
        chk(eff_type, codes[2], "frozen type");
        clk_en = 1'b1;
        @(negedge sys_clk);
        chk(eff_type, codes[0], "thawed type");
        range_regs_off = 1'b0;
        $display("test flags done");
    endtask

    // software side: no-fill, flush, ranges off, flush again
    task automatic caches_off();
        global_nofill_flag = 1'b1;
        run_op(2'h1, 32'h0);
        range_regs_off = 1'b1;
        run_op(2'h1, 32'h0);
        chk(eff_type, codes[0], "caches off type");
        chk(eff_strict_order, 1'b1, "caches off order");
        chk(read_hit_en, 1'b1, "caches off hit");
    endtask

    // third-level disable on bit 6, caches off around each toggle
    task automatic test_l3();
        caches_off();
        misc_wdata = 64'hA5A5_0000_0000_0040;
        misc_wr = 1'b1;
        @(negedge sys_clk);
        misc_wr = 1'b0;
        chk(misc_rdata, 64'hA5A5_0000_0000_0040, "misc");
        chk(l3_enable, 1'b0, "l3 off");
        {global_nofill_flag, range_regs_off} = 2'h0;
        @(negedge sys_clk);
        chk(cache_fill_en, 1'b1, "l1 fill");
        chk(l3_enable, 1'b0, "l3 stays off");
        caches_off();
        misc_wdata = 64'hFFFF_FFFF_FFFF_FFBF;
        misc_wr = 1'b1;
        @(negedge sys_clk);
        misc_wr = 1'b0;
        chk(l3_enable, 1'b1, "l3 on");
        {global_nofill_flag, range_regs_off} = 2'h0;
        $display("test l3 done");
    endtask

    // issue one maintenance request and log when each output shows
    task automatic run_op(input logic [1:0] op, input logic [31:0] a);
        int c;
        {t_inv, t_b1, t_b2, t_fl, t_done, t_wbl} = {6{32'hFFFF_FFFF}};
        {n_wb, n_bus, n_fl} = '0;
        for (c = 0; c < 8 && !req_ready; c++)
            @(negedge sys_clk);
        chk(req_ready, 1'b1, "ready");
        req_op = op;
        req_addr = a;
        req_valid = 1'b1;
        for (c = 1; c < 60 && t_done < 0; c++)
        begin
            @(negedge sys_clk);
            req_valid = 1'b0;
            if (inv_all) t_inv = c;
            if (wb_all_start) n_wb++;
            if (wb_all_start) t_wbl = c;
            if (bus_special) n_bus++;
            if (bus_special && bus_special_code == mtrc_pkg::MTRC_CMD_WBACK)
                t_b2 = c;
            if (bus_special && bus_special_code == mtrc_pkg::MTRC_CMD_INV)
                t_b1 = c;
            if (line_flush) n_fl++;
            if (line_flush) t_fl = c;
            if (line_flush) fl_addr = line_flush_addr;
            if (req_done) t_done = c;
        end
        chk(t_done > 0, 1'b1, "done seen");
    endtask

    // write-back, invalidate, then two bus cycles, prompt and slow
    task automatic test_wb_inv();
        for (int i = 0; i < 2; i++)
        begin
            lat = i ? 4'h6 : 4'h0;
            run_op(2'h1, 32'h0);
            chk(n_wb > lat, 1'b1, "waits engine");
            chk(t_inv, t_wbl + 1, "inv after wb");
            chk(t_b2, t_inv + 1, "bus wb");
            chk(t_b1, t_b2 + 1, "bus inv");
            chk(t_done, t_b1 + 1, "done");
            chk(n_bus, 2, "bus count");
        end
        $display("test wb invalidate done");
    endtask

    // invalidate-all straight after the request, with no write-back
    task automatic test_inv_all();
        run_op(2'h0, 32'h0);
        chk(t_inv, 1, "inv");
        chk(t_b1, 2, "bus inv");
        chk(t_done, 3, "done");
        chk(n_wb, 0, "no wb");
        chk(n_bus, 1, "bus count");
        $display("test invalidate done");
    endtask

    // line flush of an unaligned address, then a no-op
    task automatic test_flush();
        run_op(2'h2, 32'h1234_5679);
        chk(n_fl, 1, "flush count");
        chk(t_fl, 1, "flush time");
        chk(fl_addr, 32'h1234_5640, "flush addr");
        chk(n_bus + n_wb, 0, "flush quiet");
        run_op(2'h3, 32'h0);
        chk(n_fl + n_bus + n_wb, 0, "noop quiet");
        $display("test flush done");
    endtask

    // one store or snoop pulse and the pulses it should cause
    task automatic st(input logic [6:0] in, input logic [4:0] ex);
        {store_valid, store_nontemporal, store_hits_code_line,
            store_hits_prefetch, store_hits_trace, snoop_hits_trace,
            serialize} = in;
        @(negedge sys_clk);
        {store_valid, store_nontemporal, store_hits_code_line,
            store_hits_prefetch, store_hits_trace, snoop_hits_trace,
            serialize} = 7'h00;
        chk({store_alloc, code_line_inv, prefetch_inv, trace_inv,
            icache_resync}, ex, "store pulse");
        @(negedge sys_clk);
        chk({store_alloc, code_line_inv, prefetch_inv, trace_inv,
            icache_resync}, 5'h00, "pulse end");
    endtask

    task automatic test_stores();
        st(7'h40, 5'h10);
        st(7'h60, 5'h00);
        st(7'h50, 5'h18);
        st(7'h48, 5'h14);
        st(7'h44, 5'h12);
        st(7'h02, 5'h02);
        st(7'h01, 5'h05);
        $display("test stores done");
    endtask

    // watchdog against a hang
    initial
    begin
        #20000;
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        conclude();
    end

    // reset, then the scenarios in turn
    initial
    begin
        {nrst, global_nofill_flag, global_write_policy_flag} = 3'h0;
        {range_regs_off, page_attr_sel, page_cache_off_bit} = 3'h0;
        {page_write_through_bit, misc_wr, req_valid, req_op} = 5'h00;
        {store_valid, store_nontemporal, store_hits_code_line} = 3'h0;
        {store_hits_prefetch, store_hits_trace, snoop_hits_trace} = 3'h0;
        {serialize, range_type, lat} = 8'h00;
        {req_addr, page_attr_table, misc_wdata} = '0;
        clk_en = 1'b1;
        error_cnt = 0;
        num_checks = 0;
        repeat (12) @(negedge sys_clk);
        chk(misc_rdata, mtrc_pkg::MTRC_MISC_RST, "reset misc");
        chk({l3_enable, req_ready, eff_strict_order}, 3'h7, "reset bits");
        nrst = 1'b1;
        test_types();
        test_index();
        test_flags();
        test_l3();
        test_wb_inv();
        test_inv_all();
        test_flush();
        test_stores();
        conclude();
    end
endmodule
`default_nettype wire

// File: sim/mtrc_eng_model.sv
`timescale 1ns/1ps
`default_nettype none
// internal cache engine answering the full write-back request
module mtrc_eng_model (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic [3:0] lat,
    input  wire logic       wb_all_start,
    output logic            wb_all_done
);
    logic [3:0] cnt_r;
    logic       busy;

    // busy while start is held and not yet answered
    assign busy = wb_all_start && !wb_all_done;

    // dirty lines written back, done lat+1 cycles after start
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_r       <= 4'h0;
            wb_all_done <= 1'b0;
        end
        else
        begin
            cnt_r       <= busy ? cnt_r + 4'h1 : 4'h0;
            wb_all_done <= busy && (cnt_r >= lat);
        end
    end
endmodule
`default_nettype wire
